/* File: design/uehc_pkg.sv */
// package: register map, field positions and carrier types of the endpoint handshake control
package uehc_pkg;

    // ==========================================================
    // register map (byte addresses, 8-bit data)
    localparam logic [7:0] A_CTRL_IN = 8'h00;
    localparam logic [7:0] A_CTRL_OUT = 8'h01;
    localparam logic [7:0] A_SETUP_FLAG = 8'h02;
    localparam logic [7:0] A_READ_GATE = 8'h03;
    localparam logic [7:0] A_READ_SEL = 8'h04;
    localparam logic [7:0] A_EP_BASE = 8'h10;
    localparam logic [7:0] EP_STRIDE = 8'h04;
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h01;
    localparam logic [7:0] OFS_MAX = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ==========================================================
    // handshake control fields
    localparam int B_AUTO = 7;
    localparam int B_SPKT = 6;
    localparam int B_SNDIS = 5;
    localparam int B_TGL = 4;
    localparam int B_T1 = 3;
    localparam int B_T0 = 2;
    localparam int B_NAK = 1;
    localparam int B_STALL = 0;
    localparam int B_RSV_LO = 5;
    localparam int B_RSV_HI = 6;

    // ==========================================================
    // configuration fields
    localparam int B_DIR = 7;
    localparam int B_TMOD = 6;
    localparam int B_EN = 5;
    localparam int NUM_LSB = 0;
    localparam int NUM_W = 4;
    localparam int MAX_W = 7;
    localparam int B_GATE = 0;
    localparam int B_SETUP = 0;

    // ==========================================================
    // carrier types
    typedef enum logic [1:0] {
        HS_NORMAL = 2'h0,
        HS_NAK = 2'h1,
        HS_STALL = 2'h3,
        HS_IGNORE = 2'h2
    } uehc_hs_t;

    typedef struct packed {
        logic valid;
        logic [NUM_W-1:0] ep_num;
        logic is_in;
    } uehc_token_t;

    typedef struct packed {
        logic valid;
        logic [1:0] slot;
        logic is_in;
        logic ok;
        logic short_pkt;
    } uehc_done_t;

    typedef struct packed {
        logic valid;
        uehc_hs_t hs;
        logic [1:0] slot;
        logic toggle;
        logic short_en;
        logic [MAX_W-1:0] max_bytes;
    } uehc_resp_t;

endpackage

/* File: design/uehc_top.sv */
// module: handshake, toggle and configuration control of the control and general endpoints
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

// Behaviour
// (R1) control IN forced_nak at 1 answers every control IN with NAK
// (R2) control OUT forced_nak at 1 answers every control OUT with NAK
// (R3) setup completion sets both control forced_nak bits; clearing ignored while flag high
// (R4) setup completion clears both control forced_stall bits; setting ignored while flag high
// (R5) control IN short packet completion sets control IN forced_nak
// (R6) forced_stall answers STALL on its endpoint, winning over forced_nak
// (R7) control OUT auto_nak_arm sets control OUT forced_nak on each good OUT
// (R8) each endpoint shows a read-only toggle_state, 1 meaning DATA1
// (R9) toggle_force_one sets, toggle_force_zero clears the toggle; both read 0
// (R10) general auto_nak_arm sets forced_nak on each normal completion
// (R11) short_packet_enable sends short or zero packet, cleared after short completion
// (R12) software writes no FIFO data until short_packet_enable returns to 0
// (R13) short OUT packet sets forced_nak unless disabled; auto_nak_arm overrides
// (R14) general forced_nak at 1 answers NAK regardless of FIFO state
// (R15) general direction bit: 1 IN, 0 OUT
// (R16) toggle_policy 1 flips IN toggle every transaction, 0 only on normal end
// (R17) disabled general endpoint ignores all bus accesses addressed to it
// (R18) endpoint number 0x1 to 0xf, unique per number and direction
// (R19) software keeps max_packet_bytes legal and within the FIFO area
// (R20) read select keeps highest written bit; zeros pick control; only with gate
// (R21) software sets forced_nak before reading IN data back from a FIFO
// (R22) setup_done_flag set by setup completion, cleared only by writing 1
// (R23) CPU FIFO reads allowed only while cpu_read_gate is 1
// (R24) all control, configuration and select bits reset to 0
module uehc_top
    import uehc_pkg::*;
#(
    parameter int NUM_EP = 3
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic SETUP_DONE_I,
    input wire uehc_done_t DONE_I,
    input wire uehc_token_t TOKEN_I,
    output uehc_resp_t RESP_O,
    output logic SETUP_FLAG_O,
    output logic READ_GATE_O,
    output logic [NUM_EP:0] READ_SEL_O
);

    // ==========================================================
    // address decode
    function automatic logic ep_hit(input logic [7:0] a, input int m, input logic [7:0] ofs);
        ep_hit = (a == 8'(A_EP_BASE + EP_STRIDE * m + ofs));
    endfunction

    function automatic logic [NUM_EP-1:0] keep_highest(input logic [NUM_EP-1:0] v);
        logic found;
        found = 1'b0;
        keep_highest = '0;
        for (int i = NUM_EP - 1; i >= 0; i--) begin
            if (v[i] && !found) begin
                keep_highest[i] = 1'b1;
                found = 1'b1;
            end
        end
    endfunction

    wire wr_cin = WR_I && (ADDR_I == A_CTRL_IN);
    wire wr_cout = WR_I && (ADDR_I == A_CTRL_OUT);
    wire wr_setup = WR_I && (ADDR_I == A_SETUP_FLAG);
    wire wr_gate = WR_I && (ADDR_I == A_READ_GATE);
    wire wr_sel = WR_I && (ADDR_I == A_READ_SEL);

    // ==========================================================
    // state
    logic c_in_spkt_ff, c_in_tgl_ff, c_in_nak_ff, c_in_stall_ff;
    logic c_out_auto_ff, c_out_tgl_ff, c_out_nak_ff, c_out_stall_ff;
    logic [1:0] c_out_rsv_ff;
    logic setup_flag_ff, gate_ff;
    logic [NUM_EP-1:0] sel_ff;
    logic [NUM_EP-1:0] g_auto_ff, g_spkt_ff, g_sndis_ff, g_tgl_ff, g_nak_ff, g_stall_ff;
    logic [NUM_EP-1:0] g_dir_ff, g_tmod_ff, g_en_ff;
    logic [NUM_W-1:0] g_num_ff [NUM_EP];
    logic [MAX_W-1:0] g_max_ff [NUM_EP];
    logic [7:0] rdata_ff;
    uehc_resp_t resp_ff;
    logic [NUM_EP:0] rsel_ff;

    logic nxt_c_in_spkt, nxt_c_in_tgl, nxt_c_in_nak, nxt_c_in_stall;
    logic nxt_c_out_tgl, nxt_c_out_nak, nxt_c_out_stall;
    logic [NUM_EP-1:0] nxt_g_spkt, nxt_g_tgl, nxt_g_nak;
    logic [7:0] nxt_rdata;
    uehc_resp_t nxt_resp;

    // ==========================================================
    // completion events from the serial engine
    wire setup_hold = setup_flag_ff || SETUP_DONE_I;
    wire ev_c = DONE_I.valid && (DONE_I.slot == 2'h0);
    wire ev_cin = ev_c && DONE_I.is_in;
    wire ev_cout = ev_c && !DONE_I.is_in;
    wire nxt_setup_flag = SETUP_DONE_I || (setup_flag_ff && !(wr_setup && WDATA_I[B_SETUP])); // see R22
    wire [NUM_EP-1:0] nxt_sel = wr_sel ? keep_highest(WDATA_I[NUM_EP-1:0]) : sel_ff; // see R20
    wire [NUM_EP:0] nxt_rsel = gate_ff ? {sel_ff, ~|sel_ff} : '0; // see R20 // see R23

    // ==========================================================
    // control endpoint next state
    always_comb begin
        nxt_c_in_nak = wr_cin ? WDATA_I[B_NAK] : c_in_nak_ff;
        if (ev_cin && DONE_I.ok && DONE_I.short_pkt) begin
            nxt_c_in_nak = 1'b1; // see R5
        end
        if (setup_hold) begin
            nxt_c_in_nak = 1'b1; // see R3
        end
        nxt_c_in_stall = wr_cin ? WDATA_I[B_STALL] : c_in_stall_ff;
        if (setup_hold) begin
            nxt_c_in_stall = 1'b0; // see R4
        end
        nxt_c_in_spkt = c_in_spkt_ff;
        if (ev_cin && DONE_I.ok && DONE_I.short_pkt) begin
            nxt_c_in_spkt = 1'b0; // see R11
        end
        if (wr_cin) begin
            nxt_c_in_spkt = WDATA_I[B_SPKT];
        end
        // software force beats a flip in the same cycle
        nxt_c_in_tgl = c_in_tgl_ff ^ (ev_cin && DONE_I.ok);
        if (wr_cin && WDATA_I[B_T0]) begin
            nxt_c_in_tgl = 1'b0; // see R9
        end
        if (wr_cin && WDATA_I[B_T1]) begin
            nxt_c_in_tgl = 1'b1; // see R9
        end

        nxt_c_out_nak = wr_cout ? WDATA_I[B_NAK] : c_out_nak_ff;
        if (ev_cout && DONE_I.ok && c_out_auto_ff) begin
            nxt_c_out_nak = 1'b1; // see R7
        end
        if (setup_hold) begin
            nxt_c_out_nak = 1'b1; // see R3
        end
        nxt_c_out_stall = wr_cout ? WDATA_I[B_STALL] : c_out_stall_ff;
        if (setup_hold) begin
            nxt_c_out_stall = 1'b0; // see R4
        end
        nxt_c_out_tgl = c_out_tgl_ff ^ (ev_cout && DONE_I.ok);
        if (wr_cout && WDATA_I[B_T0]) begin
            nxt_c_out_tgl = 1'b0; // see R9
        end
        if (wr_cout && WDATA_I[B_T1]) begin
            nxt_c_out_tgl = 1'b1; // see R9
        end
    end

    // ==========================================================
    // general endpoints next state
    always_comb begin
        for (int m = 0; m < NUM_EP; m++) begin
            logic ev, wr;
            ev = 1'b0;
            wr = 1'b0;
            // a disabled endpoint has no transactions to report
            ev = DONE_I.valid && (DONE_I.slot == 2'(m + 1)) && g_en_ff[m]; // see R17
            wr = WR_I && ep_hit(ADDR_I, m, OFS_CTL);
            nxt_g_nak[m] = wr ? WDATA_I[B_NAK] : g_nak_ff[m];
            if (ev && DONE_I.ok && (g_auto_ff[m] ||
                    (!DONE_I.is_in && DONE_I.short_pkt && !g_sndis_ff[m]))) begin
                nxt_g_nak[m] = 1'b1; // see R10 // see R13
            end
            nxt_g_spkt[m] = g_spkt_ff[m];
            if (ev && DONE_I.is_in && DONE_I.ok && DONE_I.short_pkt) begin
                nxt_g_spkt[m] = 1'b0; // see R11
            end
            if (wr) begin
                nxt_g_spkt[m] = WDATA_I[B_SPKT];
            end
            nxt_g_tgl[m] = g_tgl_ff[m] ^ (ev && (DONE_I.ok || (DONE_I.is_in && g_tmod_ff[m]))); // see R16
            if (wr && WDATA_I[B_T0]) begin
                nxt_g_tgl[m] = 1'b0; // see R9
            end
            if (wr && WDATA_I[B_T1]) begin
                nxt_g_tgl[m] = 1'b1; // see R9
            end
        end
    end

    // ==========================================================
    // token lookup: answer chosen for the addressed endpoint
    always_comb begin
        nxt_resp = '0;
        nxt_resp.valid = TOKEN_I.valid;
        nxt_resp.hs = HS_IGNORE; // see R17
        if (TOKEN_I.ep_num == '0) begin
            nxt_resp.slot = 2'h0;
            if (TOKEN_I.is_in) begin
                nxt_resp.toggle = c_in_tgl_ff;
                nxt_resp.short_en = c_in_spkt_ff;
                nxt_resp.hs = c_in_stall_ff ? HS_STALL : (c_in_nak_ff ? HS_NAK : HS_NORMAL); // see R6 // see R1
            end else begin
                nxt_resp.toggle = c_out_tgl_ff;
                nxt_resp.hs = c_out_stall_ff ? HS_STALL : (c_out_nak_ff ? HS_NAK : HS_NORMAL); // see R6 // see R2
            end
        end else begin
            for (int m = 0; m < NUM_EP; m++) begin
                // direction and number must both match an enabled endpoint
                if (g_en_ff[m] && (g_num_ff[m] == TOKEN_I.ep_num) && (g_dir_ff[m] == TOKEN_I.is_in)) begin
                    nxt_resp.slot = 2'(m + 1); // see R15 // see R18
                    nxt_resp.toggle = g_tgl_ff[m];
                    nxt_resp.short_en = g_spkt_ff[m]; // see R11
                    nxt_resp.max_bytes = g_max_ff[m];
                    nxt_resp.hs = g_stall_ff[m] ? HS_STALL : (g_nak_ff[m] ? HS_NAK : HS_NORMAL); // see R6 // see R14
                end
            end
        end
    end

    // ==========================================================
    // read mux; force bits always read as zero
    always_comb begin
        nxt_rdata = '0;
        unique case (ADDR_I)
            A_CTRL_IN: begin
                nxt_rdata[B_SPKT] = c_in_spkt_ff;
                nxt_rdata[B_TGL] = c_in_tgl_ff; // see R8
                nxt_rdata[B_NAK] = c_in_nak_ff;
                nxt_rdata[B_STALL] = c_in_stall_ff;
            end
            A_CTRL_OUT: begin
                nxt_rdata[B_AUTO] = c_out_auto_ff;
                nxt_rdata[B_RSV_HI:B_RSV_LO] = c_out_rsv_ff;
                nxt_rdata[B_TGL] = c_out_tgl_ff; // see R8
                nxt_rdata[B_NAK] = c_out_nak_ff;
                nxt_rdata[B_STALL] = c_out_stall_ff;
            end
            A_SETUP_FLAG: nxt_rdata[B_SETUP] = setup_flag_ff;
            A_READ_GATE: nxt_rdata[B_GATE] = gate_ff;
            A_READ_SEL: nxt_rdata[NUM_EP-1:0] = sel_ff;
            default: begin
                for (int m = 0; m < NUM_EP; m++) begin
                    if (ep_hit(ADDR_I, m, OFS_CTL)) begin
                        nxt_rdata = {g_auto_ff[m], g_spkt_ff[m], g_sndis_ff[m], g_tgl_ff[m],
                                     2'h0, g_nak_ff[m], g_stall_ff[m]}; // see R8 // see R9
                    end
                    if (ep_hit(ADDR_I, m, OFS_CFG)) begin
                        nxt_rdata = {g_dir_ff[m], g_tmod_ff[m], g_en_ff[m], 1'b0, g_num_ff[m]};
                    end
                    if (ep_hit(ADDR_I, m, OFS_MAX)) begin
                        nxt_rdata = {1'b0, g_max_ff[m]};
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // control registers
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            c_in_spkt_ff <= 1'b0; // see R24
            c_in_tgl_ff <= 1'b0;
            c_in_nak_ff <= 1'b0;
            c_in_stall_ff <= 1'b0;
            c_out_auto_ff <= 1'b0;
            c_out_rsv_ff <= '0;
            c_out_tgl_ff <= 1'b0;
            c_out_nak_ff <= 1'b0;
            c_out_stall_ff <= 1'b0;
            setup_flag_ff <= 1'b0;
            gate_ff <= 1'b0;
            sel_ff <= '0;
        end else begin
            c_in_spkt_ff <= nxt_c_in_spkt;
            c_in_tgl_ff <= nxt_c_in_tgl;
            c_in_nak_ff <= nxt_c_in_nak;
            c_in_stall_ff <= nxt_c_in_stall;
            c_out_tgl_ff <= nxt_c_out_tgl;
            c_out_nak_ff <= nxt_c_out_nak;
            c_out_stall_ff <= nxt_c_out_stall;
            if (wr_cout) begin
                c_out_auto_ff <= WDATA_I[B_AUTO];
                c_out_rsv_ff <= WDATA_I[B_RSV_HI:B_RSV_LO];
            end
            setup_flag_ff <= nxt_setup_flag;
            if (wr_gate) begin
                gate_ff <= WDATA_I[B_GATE];
            end
            sel_ff <= nxt_sel;
        end
    end

    // ==========================================================
    // general endpoint registers, one slice per endpoint
    for (genvar m = 0; m < NUM_EP; m++) begin : g_ep
        always_ff @(posedge MCLK_I) begin
            if (RESET_I) begin
                g_auto_ff[m] <= 1'b0;
                g_spkt_ff[m] <= 1'b0;
                g_sndis_ff[m] <= 1'b0;
                g_tgl_ff[m] <= 1'b0;
                g_nak_ff[m] <= 1'b0;
                g_stall_ff[m] <= 1'b0;
                g_dir_ff[m] <= 1'b0;
                g_tmod_ff[m] <= 1'b0;
                g_en_ff[m] <= 1'b0; // see R24
                g_num_ff[m] <= '0;
                g_max_ff[m] <= REG_RESET[MAX_W-1:0];
            end else begin
                g_spkt_ff[m] <= nxt_g_spkt[m];
                g_tgl_ff[m] <= nxt_g_tgl[m];
                g_nak_ff[m] <= nxt_g_nak[m];
                if (WR_I && ep_hit(ADDR_I, m, OFS_CTL)) begin
                    g_auto_ff[m] <= WDATA_I[B_AUTO];
                    g_sndis_ff[m] <= WDATA_I[B_SNDIS];
                    g_stall_ff[m] <= WDATA_I[B_STALL];
                end
                if (WR_I && ep_hit(ADDR_I, m, OFS_CFG)) begin
                    g_dir_ff[m] <= WDATA_I[B_DIR]; // see R15
                    g_tmod_ff[m] <= WDATA_I[B_TMOD];
                    g_en_ff[m] <= WDATA_I[B_EN]; // see R17
                    g_num_ff[m] <= WDATA_I[NUM_LSB +: NUM_W];
                end
                if (WR_I && ep_hit(ADDR_I, m, OFS_MAX)) begin
                    g_max_ff[m] <= WDATA_I[MAX_W-1:0];
                end
            end
        end
    end

    // ==========================================================
    // registered outputs; read data stand for exactly one cycle
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            rdata_ff <= '0;
            resp_ff <= '0;
            rsel_ff <= '0;
        end else begin
            rdata_ff <= RD_I ? nxt_rdata : '0;
            resp_ff <= nxt_resp;
            rsel_ff <= nxt_rsel;
        end
    end

    assign RDATA_O = rdata_ff;
    assign RESP_O = resp_ff;
    assign SETUP_FLAG_O = setup_flag_ff;
    assign READ_GATE_O = gate_ff;
    assign READ_SEL_O = rsel_ff;

endmodule

/* File: verif/uehc_chk_sva.sv */
// checker: port-level assertions of the endpoint handshake control
`timescale 1ns/100ps
module uehc_chk
    import uehc_pkg::*;
#(
    parameter int NUM_EP = 3
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic SETUP_DONE_I,
    input wire uehc_done_t DONE_I,
    input wire uehc_token_t TOKEN_I,
    input wire uehc_resp_t RESP_O,
    input wire logic SETUP_FLAG_O,
    input wire logic READ_GATE_O,
    input wire logic [NUM_EP:0] READ_SEL_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    // ==========================================================
    // setup flag and forced handshakes
    a_flag_rise: assert property (SETUP_DONE_I |=> SETUP_FLAG_O)
        else $error("setup flag not raised");
    a_flag_hold: assert property (SETUP_FLAG_O && !(WR_I && ADDR_I == A_SETUP_FLAG && WDATA_I[B_SETUP]) |=> SETUP_FLAG_O)
        else $error("setup flag dropped without clear");
    a_flag_cause: assert property ($rose(SETUP_FLAG_O) |-> $past(SETUP_DONE_I))
        else $error("setup flag rose without setup completion");
    a_setup_nak: assert property (SETUP_FLAG_O && TOKEN_I.valid && TOKEN_I.ep_num == 4'h0 |=> RESP_O.hs == HS_NAK)
        else $error("control token not answered with nak during setup");
    a_tgl_readz: assert property (RD_I && (ADDR_I == A_CTRL_IN || ADDR_I == A_CTRL_OUT) |=> RDATA_O[B_T1:B_T0] == 2'h0)
        else $error("toggle force bits read nonzero");
    // ==========================================================
    // read select
    a_sel_onehot: assert property ($onehot0(READ_SEL_O))
        else $error("read select not one-hot");
    a_sel_gate: assert property (!READ_GATE_O && !$past(READ_GATE_O) |-> READ_SEL_O == '0)
        else $error("read select active without gate");
    a_gate_wr: assert property (WR_I && ADDR_I == A_READ_GATE |=> READ_GATE_O == $past(WDATA_I[B_GATE]))
        else $error("read gate does not follow write");
    c_setup: cover property (SETUP_DONE_I);
    c_stall: cover property (RESP_O.valid && RESP_O.hs == HS_STALL);
    c_sel_hi: cover property (READ_GATE_O && READ_SEL_O[NUM_EP]);
endmodule

bind uehc_top uehc_chk #(.NUM_EP(NUM_EP)) u_chk (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SETUP_DONE_I(SETUP_DONE_I),
    .DONE_I(DONE_I), .TOKEN_I(TOKEN_I), .RESP_O(RESP_O), .SETUP_FLAG_O(SETUP_FLAG_O),
    .READ_GATE_O(READ_GATE_O), .READ_SEL_O(READ_SEL_O));

/* File: verif/uehc_host.sv */
// host model: issues tokens and reports completion of answered transactions
`timescale 1ns/100ps
module uehc_host
    import uehc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [NUM_W-1:0] ep_i,
    input wire logic in_i,
    input wire logic ok_i,
    input wire logic short_i,
    input wire uehc_resp_t resp_i,
    output uehc_token_t token_o,
    output uehc_done_t done_o
);
    // ==========================================================
    // token, then completion one cycle after a normal answer; nak, stall or silence ends it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            token_o <= '0;
            done_o <= '0;
        end else begin
            token_o <= '{valid: go_i, ep_num: ep_i, is_in: in_i};
            done_o <= '{valid: resp_i.valid && resp_i.hs == HS_NORMAL, slot: resp_i.slot, is_in: in_i,
                        ok: ok_i, short_pkt: short_i};
        end
    end
endmodule

/* File: verif/usb_endpoint_handshake_ctrl_tb.sv */
// testbench: register, token and completion scenarios of the endpoint handshake control
`timescale 1ns/100ps
module usb_endpoint_handshake_ctrl_tb;
    import uehc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic setup = 1'b0;
    logic go = 1'b0;
    logic [3:0] h_ep = 4'h0;
    logic h_in = 1'b0;
    logic h_ok = 1'b0;
    logic h_sh = 1'b0;
    logic [7:0] rdata;
    logic flag;
    logic gate;
    logic [3:0] sel;
    uehc_token_t tok;
    uehc_done_t done;
    uehc_resp_t resp;
    int n_mismatch = 0;
    int compares = 0;
    always #10 clk = ~clk;
    uehc_top #(.NUM_EP(3)) u_dut (.MCLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .SETUP_DONE_I(setup), .DONE_I(done), .TOKEN_I(tok), .RESP_O(resp),
        .SETUP_FLAG_O(flag), .READ_GATE_O(gate), .READ_SEL_O(sel));
    uehc_host u_host (.clk_i(clk), .rst_i(rst), .go_i(go), .ep_i(h_ep), .in_i(h_in), .ok_i(h_ok),
        .short_i(h_sh), .resp_i(resp), .token_o(tok), .done_o(done));
    // ==========================================================
    // shared tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_hs(input uehc_hs_t exp);
        compares++;
        if (resp.valid !== 1'b1 || resp.hs !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t handshake %h expected %h", $time, resp.hs, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk8(rdata, exp);
    endtask
    // fifo contents are not modelled, so a token only ever sees the handshake decision
    task automatic xact(input logic [3:0] ep, input logic i, input logic o, input logic s, input uehc_hs_t exp);
        @(posedge clk);
        h_ep <= ep;
        h_in <= i;
        h_ok <= o;
        h_sh <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1 chk_hs(exp);
        repeat (2) @(posedge clk);
    endtask
    task automatic results();
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] regs [9] = '{A_CTRL_IN, A_CTRL_OUT, A_SETUP_FLAG, A_READ_GATE, A_READ_SEL, 8'h10, 8'h11, 8'h12, 8'hFF};
        foreach (regs[i]) rd(regs[i], REG_RESET);
    endtask
    task automatic t_ctrl_in();
        wr(A_CTRL_IN, 8'h02);
        xact(4'h0, 1'b1, 1'b1, 1'b0, HS_NAK);
        wr(A_CTRL_IN, 8'h03);
        xact(4'h0, 1'b1, 1'b1, 1'b0, HS_STALL);
        wr(A_CTRL_IN, 8'h00);
        xact(4'h0, 1'b1, 1'b1, 1'b1, HS_NORMAL);
        rd(A_CTRL_IN, 8'h12);
    endtask
    task automatic t_setup();
        wr(A_CTRL_OUT, 8'h01);
        @(posedge clk);
        setup <= 1'b1;
        @(posedge clk);
        setup <= 1'b0;
        #1 chk8({7'h0, flag}, 8'h01);
        rd(A_CTRL_OUT, 8'h02);
        wr(A_CTRL_OUT, 8'h01);
        rd(A_CTRL_OUT, 8'h02);
        xact(4'h0, 1'b1, 1'b1, 1'b0, HS_NAK);
        wr(A_SETUP_FLAG, 8'h00);
        rd(A_SETUP_FLAG, 8'h01);
        wr(A_SETUP_FLAG, 8'h01);
        rd(A_SETUP_FLAG, 8'h00);
    endtask
    task automatic t_ctrl_out();
        wr(A_CTRL_OUT, 8'h80);
        xact(4'h0, 1'b0, 1'b1, 1'b0, HS_NORMAL);
        rd(A_CTRL_OUT, 8'h92);
        xact(4'h0, 1'b0, 1'b1, 1'b0, HS_NAK);
        wr(A_CTRL_OUT, 8'h84);
        rd(A_CTRL_OUT, 8'h80);
        wr(A_CTRL_OUT, 8'h88);
        rd(A_CTRL_OUT, 8'h90);
    endtask
    task automatic t_gen_in();
        xact(4'h5, 1'b1, 1'b1, 1'b0, HS_IGNORE);
        wr(8'h12, 8'h40); // legal bulk size
        wr(8'h11, 8'hA5);
        wr(8'h10, 8'h40); // no fifo data queued while the enable stands
        xact(4'h5, 1'b1, 1'b1, 1'b1, HS_NORMAL);
        #1 chk8({1'b0, resp.max_bytes}, 8'h40);
        chk8({5'h0, resp.short_en, resp.slot}, 8'h05);
        rd(8'h10, 8'h10);
        xact(4'h5, 1'b1, 1'b0, 1'b0, HS_NORMAL);
        #1 chk8({7'h0, resp.toggle}, 8'h01);
        rd(8'h10, 8'h10);
        wr(8'h11, 8'hE5);
        xact(4'h5, 1'b1, 1'b0, 1'b0, HS_NORMAL);
        rd(8'h10, 8'h00);
        wr(8'h10, 8'h80);
        xact(4'h5, 1'b1, 1'b1, 1'b0, HS_NORMAL);
        rd(8'h10, 8'h92);
        xact(4'h5, 1'b1, 1'b1, 1'b0, HS_NAK);
        wr(8'h10, 8'h03);
        xact(4'h5, 1'b1, 1'b1, 1'b0, HS_STALL);
    endtask
    task automatic t_gen_out();
        wr(8'h15, 8'h25); // same number, other direction
        xact(4'h5, 1'b0, 1'b1, 1'b1, HS_NORMAL);
        #1 chk8({6'h0, resp.slot}, 8'h02);
        rd(8'h14, 8'h12);
        wr(8'h14, 8'h20);
        xact(4'h5, 1'b0, 1'b1, 1'b1, HS_NORMAL);
        rd(8'h14, 8'h20);
    endtask
    task automatic t_sel();
        wr(A_READ_SEL, 8'h06);
        rd(A_READ_SEL, 8'h04);
        chk8({4'h0, sel}, 8'h00);
        wr(8'h18, 8'h02);
        rd(8'h18, 8'h02);
        wr(A_READ_GATE, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk8({4'h0, sel}, 8'h08);
        chk8({7'h0, gate}, 8'h01);
        wr(A_READ_SEL, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk8({4'h0, sel}, 8'h01);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ctrl_in();
        t_setup();
        t_ctrl_out();
        t_gen_in();
        t_gen_out();
        t_sel();
        results();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule
